/* rtl/uss_slave.sv */
// Synchronous slave serial transmitter/receiver with APB registers
`timescale 1ns/1ns
`default_nettype none
module uss_slave (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        shift_clk_in,
   input  wire logic        data_in,
   output logic             data_out,
   output logic             data_out_en_n,
   output logic             irq,
   output logic             wake
);
   logic        ck_level;
   logic        ck_rise;
   logic        ck_fall;
   logic        din_meta;
   logic        din_sync;

   logic [7:0]  irq_flags_en;
   logic [7:0]  irq_prio;
   logic [7:0]  rx_ctrl;
   logic [7:0]  tx_ctrl;
   logic [7:0]  bit_rate;
   logic [7:0]  tx_hold;
   logic        tx_hold_bit9;
   logic        tx_hold_full;
   logic [8:0]  tx_shift;
   logic [3:0]  tx_count;
   logic        tx_busy;
   logic        tx_flag;
   logic [8:0]  rx_shift;
   logic [3:0]  rx_count;
   logic [7:0]  rx_hold;
   logic        rx_hold_bit9;
   logic        rx_flag;
   logic        rx_overrun;
   logic [2:0]  ev_status;
   logic [2:0]  ev_mask;

   logic        acc;
   logic        wr;
   logic        rd;
   logic        slave_mode;
   logic        port_on;
   logic        tx_on;
   logic        rx_on;
   logic        tx_load;
   logic        tx_done;
   logic        rx_done;
   logic [3:0]  frame_len;
   logic [8:0]  rx_word;
   logic [7:0]  tx_stat_rd;
   logic [7:0]  rx_stat_rd;
   logic [7:0]  flags_rd;
   logic [31:0] next_prdata;
   logic [2:0]  ev_set;
   logic        tx_hold_wr;
   logic        rx_hold_rd;
   logic        evt_rd;
   logic        rx_drop;

   // Zero-extend a byte into a bus word
   function automatic logic [31:0] uss_word(input logic [7:0] b);
      return {24'h000000, b};
   endfunction

   // Register hit for one strobe; keeps the three side-effect strobe compares identical
   function automatic logic uss_hit(input logic strobe, input logic [7:0] a,
                                    input logic [7:0] target);
      return strobe & (a == target);
   endfunction

   // Bits per word for the nine-bit option
   function automatic logic [3:0] uss_frame_len(input logic nine);
      return nine ? uss_pkg::BITS_NINE : uss_pkg::BITS_EIGHT;
   endfunction

   // Addresses past the map or off a word boundary answer with an error
   function automatic logic uss_bad_addr(input logic [7:0] a);
      return (a > uss_pkg::ADDR_EVT_MASK) | (a[1:0] != 2'h0);
   endfunction

   // Clock pin is sampled, never used as a clock, so no second domain
   uss_edge_sync u_ck (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (shift_clk_in),
      .level    (ck_level),
      .rise     (ck_rise),
      .fall     (ck_fall)
   );

   // Data pin synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         din_meta <= 1'b1;
         din_sync <= 1'b1;
      end else begin
         din_meta <= data_in;
         din_sync <= din_meta;
      end
   end

   // Mode decode; single-receive enable is deliberately left out
   // Leaving it out of every term keeps its value from touching reception
   assign slave_mode = ~tx_ctrl[uss_pkg::TS_CLKSRC] & tx_ctrl[uss_pkg::TS_SYNC];
   assign port_on    = rx_ctrl[uss_pkg::RS_PORT_EN] & slave_mode;
   assign tx_on      = port_on & tx_ctrl[uss_pkg::TS_TX_EN];
   assign rx_on      = port_on & rx_ctrl[uss_pkg::RS_CONT];
   assign frame_len  = uss_frame_len(tx_ctrl[uss_pkg::TS_NINE]);

   // APB decode: zero wait states
   assign acc = psel & penable;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;

   // Strobes for the registers whose access has side effects
   assign tx_hold_wr = uss_hit(wr, paddr, uss_pkg::ADDR_TX_HOLD);
   assign rx_hold_rd = uss_hit(rd, paddr, uss_pkg::ADDR_RX_HOLD);
   assign evt_rd     = uss_hit(rd, paddr, uss_pkg::ADDR_EVT_STATUS);

   // Transmit sequencing
   assign tx_load = tx_on & tx_hold_full & (~tx_busy | tx_done);
   // Last bit leaves on the final falling edge of the word; the count
   // starts at zero on load, so the end point is one less than the length
   assign tx_done = tx_busy & ck_fall & (tx_count == frame_len - 4'h1);
   // Received word assembled from shift register and the last sampled bit
   assign rx_word = rx_ctrl[uss_pkg::RS_NINE] ? {din_sync, rx_shift[8:1]}
                                              : {1'b0, din_sync, rx_shift[8:2]};
   assign rx_done = rx_on & ck_rise
                    & (rx_count == uss_frame_len(rx_ctrl[uss_pkg::RS_NINE]) - 4'h1);
   // A word landing on an unread one is dropped; a read in that cycle saves it
   assign rx_drop = rx_done & rx_flag & ~rx_hold_rd;

   // Transmit holding register; writes while full overwrite the pending word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_hold      <= uss_pkg::BYTE_ZERO;
         tx_hold_bit9 <= 1'b0;
         tx_hold_full <= 1'b0;
      end else if (tx_hold_wr) begin
         tx_hold      <= pwdata[7:0];
         tx_hold_bit9 <= tx_ctrl[uss_pkg::TS_BIT9];
         tx_hold_full <= 1'b1;
      end else if (tx_load) begin
         tx_hold_full <= 1'b0;
      end
   end

   // Transmit shifter: bit changes on falling external edge, LSB first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_shift <= 9'h1FF;
         tx_count <= 4'h0;
         tx_busy  <= 1'b0;
      end else if (!tx_on) begin
         tx_busy  <= 1'b0;
         tx_count <= 4'h0;
      end else if (tx_load) begin
         tx_shift <= {tx_hold_bit9, tx_hold};
         tx_count <= 4'h0;
         tx_busy  <= 1'b1;
      end else if (tx_done) begin
         tx_busy  <= 1'b0;
      end else if (tx_busy && ck_fall) begin
         tx_shift <= {1'b1, tx_shift[8:1]};
         tx_count <= tx_count + 4'h1;
      end
   end

   // Transmit flag: set once the holding register has emptied
   // A write that meets an empty holding register clears the flag first;
   // it sets again once the shifter has taken the word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_flag <= 1'b0;
      end else if (tx_hold_wr) begin
         tx_flag <= 1'b0;
      end else if (!tx_hold_full) begin
         tx_flag <= 1'b1;
      end
   end

   // Data pin drive, low enable whenever the transmitter is on, idle or sending
   // The line keeps the last bit once a word ends; the master ignores it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out      <= 1'b1;
         data_out_en_n <= 1'b1;
      end else begin
         data_out      <= tx_shift[0];
         data_out_en_n <= ~tx_on;
      end
   end

   // Receive shifter samples on rising external edge, LSB first
   // Count restarts whenever continuous receive is off, so a frame cut
   // short by software leaves no stale bits for the next word
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_shift <= 9'h000;
         rx_count <= 4'h0;
      end else if (!rx_on) begin
         rx_count <= 4'h0;
      end else if (rx_done) begin
         rx_count <= 4'h0;
      end else if (ck_rise) begin
         rx_shift <= {din_sync, rx_shift[8:1]};
         rx_count <= rx_count + 4'h1;
      end
   end

   // Receive holding, flag and overrun; data read clears the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_hold      <= uss_pkg::BYTE_ZERO;
         rx_hold_bit9 <= 1'b0;
         rx_flag      <= 1'b0;
         rx_overrun   <= 1'b0;
      end else begin
         if (rx_drop) begin
            rx_overrun <= 1'b1; // Previous word not yet read; keep it
         end else if (rx_done) begin
            rx_hold      <= rx_word[7:0];
            rx_hold_bit9 <= rx_word[8];
            rx_flag      <= 1'b1;
         end else if (rx_hold_rd) begin
            rx_flag <= 1'b0;
         end
         if (!rx_ctrl[uss_pkg::RS_CONT]) begin
            rx_overrun <= 1'b0;
         end
      end
   end

   // Control registers written by software
   // The priority and divisor bytes are storage only; the external master
   // sets the bit rate, so the divisor never reaches the shifters
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_flags_en <= uss_pkg::BYTE_ZERO;
         irq_prio     <= uss_pkg::BYTE_ZERO;
         rx_ctrl      <= uss_pkg::BYTE_ZERO;
         tx_ctrl      <= uss_pkg::TS_RESET;
         bit_rate     <= uss_pkg::BYTE_ZERO;
         ev_mask      <= uss_pkg::EV_NONE;
      end else if (wr) begin
         case (paddr)
            uss_pkg::ADDR_IRQ_ENABLE: irq_flags_en <= pwdata[7:0] & uss_pkg::IRQ_IMPL_MASK;
            uss_pkg::ADDR_IRQ_PRIO:   irq_prio     <= pwdata[7:0] & uss_pkg::IRQ_IMPL_MASK;
            uss_pkg::ADDR_RX_STATUS:  rx_ctrl      <= pwdata[7:0] & uss_pkg::RS_WR_MASK;
            uss_pkg::ADDR_TX_STATUS:  tx_ctrl      <= pwdata[7:0] & uss_pkg::TS_WR_MASK;
            uss_pkg::ADDR_BIT_RATE:   bit_rate     <= pwdata[7:0];
            uss_pkg::ADDR_EVT_MASK:   ev_mask      <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // Sticky events; an event in the reading cycle survives the clear
   // Only the bits that the read returned are cleared, so an event in the
   // setup cycle is not lost between snapshot and clear
   assign ev_set = {rx_drop, rx_done & ~rx_drop, tx_load};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_status <= uss_pkg::EV_NONE;
      end else if (evt_rd) begin
         ev_status <= (ev_status & ~prdata[2:0]) | ev_set;
      end else begin
         ev_status <= ev_status | ev_set;
      end
   end

   // Read views; unimplemented bits are zero, empty bit shows idle shifter
   assign tx_stat_rd = (tx_ctrl & uss_pkg::TS_WR_MASK)
                       | ({7'h00, ~tx_busy} << uss_pkg::TS_EMPTY);
   assign rx_stat_rd = (rx_ctrl & uss_pkg::RS_WR_MASK)
                       | ({7'h00, rx_overrun} << uss_pkg::RS_OVERRUN)
                       | {7'h00, rx_hold_bit9};
   assign flags_rd   = ({7'h00, rx_flag} << uss_pkg::IRQ_RX)
                       | ({7'h00, tx_flag} << uss_pkg::IRQ_TX);

   always_comb begin
      case (paddr)
         uss_pkg::ADDR_IRQ_FLAGS:  next_prdata = uss_word(flags_rd);
         uss_pkg::ADDR_IRQ_ENABLE: next_prdata = uss_word(irq_flags_en);
         uss_pkg::ADDR_IRQ_PRIO:   next_prdata = uss_word(irq_prio);
         uss_pkg::ADDR_RX_STATUS:  next_prdata = uss_word(rx_stat_rd);
         uss_pkg::ADDR_RX_HOLD:    next_prdata = uss_word(rx_hold);
         uss_pkg::ADDR_TX_STATUS:  next_prdata = uss_word(tx_stat_rd);
         uss_pkg::ADDR_BIT_RATE:   next_prdata = uss_word(bit_rate);
         uss_pkg::ADDR_EVT_STATUS: next_prdata = uss_word({5'h00, ev_status});
         uss_pkg::ADDR_EVT_MASK:   next_prdata = uss_word({5'h00, ev_mask});
         default:                  next_prdata = 32'h00000000;
      endcase
   end

   // Read data registered in setup phase so it is valid in the access phase
   // Zero wait states: pready follows every setup cycle by exactly one
   // clock, so a master that holds its request never stretches a transfer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= (psel && !penable && !pwrite) ? next_prdata : 32'h00000000;
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & uss_bad_addr(paddr);
      end
   end

   // Interrupt and wake outputs, both registered
   // Wake ignores the event mask: it follows the flags and their enables,
   // so a masked event can still end sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq  <= 1'b0;
         wake <= 1'b0;
      end else begin
         irq  <= |(ev_status & ev_mask);
         wake <= (tx_flag & irq_flags_en[uss_pkg::IRQ_TX])
                 | (rx_flag & irq_flags_en[uss_pkg::IRQ_RX]);
      end
   end
endmodule
`default_nettype wire

/* rtl/uss_pkg.sv */
// Package of constants for the synchronous slave serial port
// How it works
// - Shift clock comes from the external pin; the master drives every bit.
// - Slave operation when clock source select is zero and sync mode is set.
// - Shifting continues during processor sleep, clocked externally.
// - Idle shifter loads a written holding word at once and sends it.
// - Second word waits in holding register; transmit flag stays clear.
// - Last bit out loads pending word, then transmit flag sets.
// - Transmit flag with its enable raises wake; interrupt comes from masked events.
// - Ninth transmit bit loaded before data word is sent with it.
// - Single-receive enable has no effect in slave receive.
// - With continuous receive on, a word is accepted during sleep.
// - Finished word copies into holding register; enabled interrupt wakes chip.
// - Receive flag sets on completion; wake if its enable is set.
// - Ninth bit and errors stay valid for the word until data read.
// - Clearing continuous receive clears latched receive errors.
// - Unimplemented register bits read as zero.
package uss_pkg;
   // Register byte addresses on APB
   localparam logic [7:0] ADDR_IRQ_FLAGS  = 8'h00;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h04;
   localparam logic [7:0] ADDR_IRQ_PRIO   = 8'h08;
   localparam logic [7:0] ADDR_RX_STATUS  = 8'h0C;
   localparam logic [7:0] ADDR_RX_HOLD    = 8'h10;
   localparam logic [7:0] ADDR_TX_HOLD    = 8'h14;
   localparam logic [7:0] ADDR_TX_STATUS  = 8'h18;
   localparam logic [7:0] ADDR_BIT_RATE   = 8'h1C;
   localparam logic [7:0] ADDR_EVT_STATUS = 8'h20;
   localparam logic [7:0] ADDR_EVT_MASK   = 8'h24;

   // Interrupt flag / enable bit positions
   localparam int unsigned IRQ_RX  = 5;
   localparam int unsigned IRQ_TX  = 4;
   localparam logic [7:0]  IRQ_IMPL_MASK = 8'h7F;

   // Receive status/control field positions
   localparam int unsigned RS_PORT_EN = 7;
   localparam int unsigned RS_NINE    = 6;
   localparam int unsigned RS_SINGLE  = 5;
   localparam int unsigned RS_CONT    = 4;
   localparam int unsigned RS_FRAME   = 2;
   localparam int unsigned RS_OVERRUN = 1;
   localparam int unsigned RS_BIT9    = 0;
   localparam logic [7:0]  RS_WR_MASK = 8'hF0;

   // Transmit status/control field positions
   localparam int unsigned TS_CLKSRC  = 7;
   localparam int unsigned TS_NINE    = 6;
   localparam int unsigned TS_TX_EN   = 5;
   localparam int unsigned TS_SYNC    = 4;
   localparam int unsigned TS_ADDR    = 3;
   localparam int unsigned TS_HIGHSPD = 2;
   localparam int unsigned TS_EMPTY   = 1;
   localparam int unsigned TS_BIT9    = 0;
   localparam logic [7:0]  TS_WR_MASK = 8'hFD;
   localparam logic [7:0]  TS_RESET   = 8'h02;

   // Event status bits (sticky, cleared by reading)
   localparam int unsigned EV_TX = 0;
   localparam int unsigned EV_RX = 1;
   localparam int unsigned EV_OV = 2;
   localparam logic [2:0]  EV_NONE = 3'h0;

   localparam logic [7:0]  BYTE_ZERO  = 8'h00;
   localparam logic [3:0]  BITS_EIGHT = 4'h8;
   localparam logic [3:0]  BITS_NINE  = 4'h9;
endpackage

/* rtl/uss_edge_sync.sv */
// Two-flop synchroniser with edge pulses for the external shift clock
`timescale 1ns/1ns
`default_nettype none
module uss_edge_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic async_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic meta;
   logic sync;
   logic last;

   // First flop feeds only the second; edges come from the settled stages
   // Stages reset to the low idle level of the clock pin, so no false edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync <= 1'b0;
         last <= 1'b0;
      end else begin
         meta <= async_in;
         sync <= meta;
         last <= sync;
      end
   end

   assign level = sync;
   assign rise  = sync & ~last;
   assign fall  = ~sync & last;
endmodule
`default_nettype wire

/* dv/uss_properties.sv */
// Concurrent checks on the slave serial port's pins
`timescale 1ns/1ns
`default_nettype none
module uss_checker (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        shift_clk_in,
   input wire logic        data_in,
   input wire logic        data_out,
   input wire logic        data_out_en_n,
   input wire logic        irq,
   input wire logic        wake
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Bus phases, and a shift clock held high long enough to settle
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   sequence s_sck_high; $rose(shift_clk_in) ##1 shift_clk_in [*6]; endsequence

   property p_access_ready; s_setup ##1 s_access |-> pready; endproperty
   a_access_ready: assert property (p_access_ready) else $error("ready missing");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
   property p_prdata_idle; !pready |-> prdata == 32'h0; endproperty
   a_prdata_idle: assert property (p_prdata_idle) else $error("read data leaks");
   property p_upper_zero; pready && !pwrite |-> prdata[31:8] == 24'h0; endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   property p_slverr_ready; pslverr |-> pready; endproperty
   a_slverr_ready: assert property (p_slverr_ready) else $error("lone error");
   property p_unmapped;
      (psel && !penable && paddr > 8'h24) ##1 s_access |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped answered");
   // Output bit may only move after a falling shift edge; checked six clocks into each high phase
   property p_sck_stable; s_sck_high |-> $stable(data_out); endproperty
   a_sck_stable: assert property (p_sck_stable) else $error("bit moved early");
   property p_rst_quiet; $rose(rst_n) |-> data_out && data_out_en_n && !irq && !wake; endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("pins busy at reset");
endmodule
bind uss_slave uss_checker u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .shift_clk_in(shift_clk_in), .data_in(data_in), .data_out(data_out),
   .data_out_en_n(data_out_en_n), .irq(irq), .wake(wake));
`default_nettype wire

/* dv/uss_master_model.sv */
// External master that clocks frames into and out of the port
`timescale 1ns/1ns
`default_nettype none
module uss_master_model (
   output logic      shift_clk,
   output logic      data_to_dev,
   input  wire logic data_from_dev
);
   logic [8:0] got;

   // Clock idles low between frames
   initial begin
      shift_clk = 1'b0;
      data_to_dev = 1'b1;
      got = 9'h000;
   end

   // One frame, LSB first; half sets a prompt or slow rate
   task automatic frame(input logic [8:0] tx, input int nbits, input int half);
      got = 9'h000;
      for (int i = 0; i < nbits; i++) begin
         data_to_dev = tx[i];
         #(half);
         got[i] = data_from_dev;
         shift_clk = 1'b1;
         #(half);
         shift_clk = 1'b0;
      end
      #(half);
      // No pull on this line, so it must not keep the last bit
      data_to_dev = ~data_to_dev;
   endtask
endmodule
`default_nettype wire

/* dv/usart_sync_slave_tb_top.sv */
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ns
`default_nettype none
module usart_sync_slave_tb_top;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic        sck, din, dout, dout_en_n, irq, wake;
   logic [7:0]  paddr, a, b;
   logic [31:0] pwdata, prdata, rd, seed;
   int          fail_count, checks_done;

   uss_slave uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shift_clk_in(sck), .data_in(din),
      .data_out(dout), .data_out_en_n(dout_en_n), .irq(irq), .wake(wake));
   uss_master_model mdl (.shift_clk(sck), .data_to_dev(din), .data_from_dev(dout));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   // Expected serial word: ninth bit only when the nine-bit option is on
   function automatic logic [31:0] wire_word(input logic [7:0] d, input logic n, input logic b9);
      return {23'h0, n & b9, d};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      if (pready !== 1'b1) fail_count++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      apb(1'b1, ad, wd);
   endtask

   task automatic rdc(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, ad, 32'h0);
      check(rd & m, e);
   endtask

   task automatic summarize();
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Cuts a hang short; the whole run needs far less
   initial begin
      #100000;
      fail_count++;
      summarize();
   end

   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      seed = 32'h8;
      fail_count = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdc(uss_pkg::ADDR_TX_STATUS, 32'hFFFFFFFF, 32'h02);
      rdc(uss_pkg::ADDR_RX_STATUS, 32'hFFFFFFFF, 32'h00);
      rdc(8'h28, 32'hFFFFFFFF, 32'h00);
      // Two words back to back: first shifts, second waits
      wr(uss_pkg::ADDR_IRQ_ENABLE, 32'h10);
      wr(uss_pkg::ADDR_RX_STATUS, 32'h80);
      wr(uss_pkg::ADDR_TX_STATUS, 32'h30);
      seed = xs(seed);
      a = seed[7:0];
      b = seed[15:8];
      wr(uss_pkg::ADDR_TX_HOLD, {24'h0, a});
      wr(uss_pkg::ADDR_TX_HOLD, {24'h0, b});
      rdc(uss_pkg::ADDR_IRQ_FLAGS, 32'h10, 32'h00);
      check({31'h0, wake}, 32'h0);
      mdl.frame(9'h000, 8, 32);
      check({23'h0, mdl.got}, wire_word(a, 1'b0, 1'b0));
      rdc(uss_pkg::ADDR_IRQ_FLAGS, 32'h10, 32'h10);
      check({30'h0, irq, wake}, 32'h1);
      mdl.frame(9'h000, 8, 32);
      check({23'h0, mdl.got}, wire_word(b, 1'b0, 1'b0));
      wr(uss_pkg::ADDR_TX_STATUS, 32'h71);
      seed = xs(seed);
      wr(uss_pkg::ADDR_TX_HOLD, {24'h0, seed[7:0]});
      mdl.frame(9'h000, 9, 32);
      check({23'h0, mdl.got}, wire_word(seed[7:0], 1'b1, 1'b1));
      // Receive with single-receive also set, which must not matter
      wr(uss_pkg::ADDR_TX_STATUS, 32'h10);
      wr(uss_pkg::ADDR_IRQ_ENABLE, 32'h20);
      wr(uss_pkg::ADDR_EVT_MASK, 32'h02);
      wr(uss_pkg::ADDR_RX_STATUS, 32'hB0);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : seed[7:0];
         mdl.frame({1'b0, a}, 8, 32);
         repeat (4) @(posedge clk);
         check({30'h0, irq, wake}, 32'h3);
         rdc(uss_pkg::ADDR_IRQ_FLAGS, 32'h20, 32'h20);
         rdc(uss_pkg::ADDR_RX_STATUS, 32'h07, 32'h00);
         rdc(uss_pkg::ADDR_RX_HOLD, 32'hFFFFFFFF, wire_word(a, 1'b0, 1'b0));
         rdc(uss_pkg::ADDR_EVT_STATUS, 32'h02, 32'h02);
         repeat (2) @(posedge clk);
         check({30'h0, irq, wake}, 32'h0);
      end
      // Unread word then another: the second overruns
      mdl.frame(9'h05A, 8, 32);
      mdl.frame(9'h0A5, 8, 32);
      rdc(uss_pkg::ADDR_RX_STATUS, 32'h02, 32'h02);
      rdc(uss_pkg::ADDR_RX_HOLD, 32'hFF, 32'h5A);
      wr(uss_pkg::ADDR_RX_STATUS, 32'h80);
      rdc(uss_pkg::ADDR_RX_STATUS, 32'h06, 32'h00);
      wr(uss_pkg::ADDR_RX_STATUS, 32'hFF);
      rdc(uss_pkg::ADDR_RX_STATUS, 32'h08, 32'h00);
      // Plain storage registers keep random bytes; priority has no bit 7
      seed = xs(seed);
      wr(uss_pkg::ADDR_BIT_RATE, seed);
      rdc(uss_pkg::ADDR_BIT_RATE, 32'hFFFFFFFF, {24'h0, seed[7:0]});
      wr(uss_pkg::ADDR_IRQ_PRIO, seed);
      rdc(uss_pkg::ADDR_IRQ_PRIO, 32'hFFFFFFFF, {25'h0, seed[6:0]});
      summarize();
   end
endmodule
`default_nettype wire
